// ---- rtl/arcc_regs.vh ----
// register offsets, field positions, reset values and encodings
`ifndef ARCC_REGS_VH
`define ARCC_REGS_VH
// ----------------------------------------
// byte offsets
// ----------------------------------------
`define ARCC_OFF_RESULT_HIGH 12'h000
`define ARCC_OFF_RESULT_LOW 12'h004
`define ARCC_OFF_CMP_HIGH 12'h008
`define ARCC_OFF_CMP_LOW 12'h00c
`define ARCC_OFF_CONFIG 12'h010
`define ARCC_OFF_PIN_CTRL 12'h014
`define ARCC_OFF_CMP_CTRL 12'h018
// ----------------------------------------
// configuration fields
// ----------------------------------------
`define ARCC_CFG_LOW_POWER 7
`define ARCC_CFG_DIV_HI 6
`define ARCC_CFG_DIV_LO 5
`define ARCC_CFG_LONG_SAMPLE 4
`define ARCC_CFG_MODE_HI 3
`define ARCC_CFG_MODE_LO 2
`define ARCC_CFG_CLK_HI 1
`define ARCC_CFG_CLK_LO 0
`define ARCC_MODE_8BIT 2'h0
`define ARCC_MODE_10BIT 2'h2
`define ARCC_CLK_BUS 2'h0
`define ARCC_CLK_BUS_HALF 2'h1
`define ARCC_CLK_ALT 2'h2
`define ARCC_CLK_ASYNC 2'h3
// ----------------------------------------
// compare control fields
// ----------------------------------------
`define ARCC_CC_ENABLE 0
`define ARCC_CC_GE 1
// ----------------------------------------
// reset values
// ----------------------------------------
`define ARCC_RST_CONFIG 8'h00
`define ARCC_RST_CMP 8'h00
`define ARCC_RST_PIN_CTRL 8'h00
`define ARCC_RST_RESULT 8'h00
`endif

// ---- rtl/arcc_clk_div.v ----
// converter clock enable generator: source select and divider
`default_nettype none
module arcc_clk_div (
    // clock and reset
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // selection
    input wire [1:0] src_sel,
    input wire [1:0] div_sel,
    input wire alt_tick,
    input wire async_tick,
    // output
    output reg conv_tick
);
`include "arcc_regs.vh"
reg half;
reg [2:0] cnt;
reg src_tick;
wire [2:0] lim = (3'h1 << div_sel) - 3'h1;
always @* begin
    case (src_sel)
        `ARCC_CLK_BUS: src_tick = 1'b1;
        `ARCC_CLK_BUS_HALF: src_tick = half;
        `ARCC_CLK_ALT: src_tick = alt_tick;
        default: src_tick = async_tick;
    endcase
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        half <= 1'b0;
        cnt <= 3'h0;
        conv_tick <= 1'b0;
    end else if (clk_en) begin
        half <= ~half;
        conv_tick <= 1'b0;
        if (src_tick) begin
            if (cnt >= lim) begin
                cnt <= 3'h0;
                conv_tick <= 1'b1;
            end else begin
                cnt <= cnt + 3'h1;
            end
        end
    end
end
endmodule // arcc_clk_div
`default_nettype wire

// ---- rtl/arcc_compare.v ----
// compare of a finished result against the compare value
`default_nettype none
module arcc_compare (
    // operands
    input wire [9:0] result,
    input wire [1:0] cmp_high,
    input wire [7:0] cmp_low,
    input wire ten_bit,
    input wire greater_equal,
    // verdict
    output wire hit
);
wire [9:0] res_eff = ten_bit ? result : {2'h0, result[7:0]};
wire [9:0] cmp_eff = ten_bit ? {cmp_high, cmp_low} : {2'h0, cmp_low};
assign hit = greater_equal ? (res_eff >= cmp_eff) : (res_eff < cmp_eff);
endmodule // arcc_compare
`default_nettype wire

// ---- rtl/arcc_top.v ----
// converter result, compare, configuration and pin control registers
// Function
// - low result holds low eight result bits
// - results stored unless compare enabled and missed
// - ten-bit high read locks until low read
// - results finishing while locked are dropped
// - eight-bit mode has no read interlock
// - mode change invalidates the low result
// - compare high bits match result upper bits
// - eight-bit compare ignores compare high register
// - compare low bits match result low bits
// - bit 7 selects low power
// - bits 6:5 divide converter clock
// - bit 4 selects long sample
// - bits 3:2 select resolution mode
// - bits 1:0 select converter clock source
// - pin control bit n governs channel n
// - high result upper bits, zero in eight-bit
// - compare less than, or greater-equal when set
// - pin bit disables output, input, pullup
//
// The address map and register access over APB were chosen for this implementation.
`default_nettype none
module arcc_top #(
    parameter CHANNELS = 8
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // converter core
    input wire conv_done,
    input wire [9:0] conv_result,
    input wire alt_tick,
    input wire async_tick,
    output reg conv_tick,
    output reg low_power,
    output reg long_sample,
    output reg ten_bit_mode,
    output reg result_valid,
    // pins
    output reg [CHANNELS-1:0] pin_out_disable,
    output reg [CHANNELS-1:0] pin_in_disable,
    output reg [CHANNELS-1:0] pin_pullup_disable
);
`include "arcc_regs.vh"
// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] result_low;
reg [1:0] result_high;
reg [7:0] compare_value_high;
reg [7:0] compare_value_low;
reg [7:0] converter_configuration;
reg [CHANNELS-1:0] analog_pin_control_lo;
reg compare_enable;
reg compare_greater_equal_select;
reg locked;
reg low_valid;
wire ten_bit = converter_configuration[`ARCC_CFG_MODE_HI:`ARCC_CFG_MODE_LO]
    == `ARCC_MODE_10BIT;
wire access = psel && penable && pready;
wire wr = access && pwrite;
wire rd = access && !pwrite;
wire cmp_hit;
wire tick;
// ----------------------------------------
// compare and clock
// ----------------------------------------
arcc_compare u_cmp (
    .result(conv_result),
    .cmp_high(compare_value_high[1:0]),
    .cmp_low(compare_value_low),
    .ten_bit(ten_bit),
    .greater_equal(compare_greater_equal_select),
    .hit(cmp_hit)
);
arcc_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .src_sel(converter_configuration[`ARCC_CFG_CLK_HI:`ARCC_CFG_CLK_LO]),
    .div_sel(converter_configuration[`ARCC_CFG_DIV_HI:`ARCC_CFG_DIV_LO]),
    .alt_tick(alt_tick),
    .async_tick(async_tick),
    .conv_tick(tick)
);
wire store = conv_done && (!compare_enable || cmp_hit)
    && !(locked && ten_bit);
wire mode_wr = wr && (paddr == `ARCC_OFF_CONFIG) && (pwdata[3:2] !=
    converter_configuration[`ARCC_CFG_MODE_HI:`ARCC_CFG_MODE_LO]);
// ----------------------------------------
// result and interlock
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        result_low <= `ARCC_RST_RESULT;
        result_high <= 2'h0;
        locked <= 1'b0;
        low_valid <= 1'b0;
    end else if (clk_en) begin
        if (store) begin
            result_low <= conv_result[7:0];
            result_high <= ten_bit ? conv_result[9:8] : 2'h0;
        end
        if (store)
            low_valid <= 1'b1;
        else if (mode_wr)
            low_valid <= 1'b0;
        if (rd && paddr == `ARCC_OFF_RESULT_LOW)
            locked <= 1'b0;
        else if (rd && paddr == `ARCC_OFF_RESULT_HIGH && ten_bit)
            locked <= 1'b1;
        else if (!ten_bit)
            locked <= 1'b0;
    end
end
// ----------------------------------------
// writable registers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        compare_value_high <= `ARCC_RST_CMP;
        compare_value_low <= `ARCC_RST_CMP;
        converter_configuration <= `ARCC_RST_CONFIG;
        analog_pin_control_lo <= {CHANNELS{1'b0}};
        compare_enable <= 1'b0;
        compare_greater_equal_select <= 1'b0;
    end else if (clk_en && wr) begin
        if (paddr == `ARCC_OFF_CMP_HIGH) begin
            compare_value_high <= {6'h00, pwdata[1:0]};
        end else if (paddr == `ARCC_OFF_CMP_LOW) begin
            compare_value_low <= pwdata[7:0];
        end else if (paddr == `ARCC_OFF_CONFIG) begin
            converter_configuration <= pwdata[7:0];
        end else if (paddr == `ARCC_OFF_PIN_CTRL) begin
            analog_pin_control_lo <= pwdata[CHANNELS-1:0];
        end else if (paddr == `ARCC_OFF_CMP_CTRL) begin
            compare_enable <= pwdata[`ARCC_CC_ENABLE];
            compare_greater_equal_select <= pwdata[`ARCC_CC_GE];
        end
    end
end
// ----------------------------------------
// apb read and answer
// ----------------------------------------
reg [31:0] next_prdata;
reg next_err;
always @* begin
    next_prdata = 32'h0;
    next_err = 1'b0;
    if (paddr == `ARCC_OFF_RESULT_HIGH) begin
        next_prdata = {30'h0, result_high};
    end else if (paddr == `ARCC_OFF_RESULT_LOW) begin
        next_prdata = {24'h0, result_low};
    end else if (paddr == `ARCC_OFF_CMP_HIGH) begin
        next_prdata = {24'h0, compare_value_high};
    end else if (paddr == `ARCC_OFF_CMP_LOW) begin
        next_prdata = {24'h0, compare_value_low};
    end else if (paddr == `ARCC_OFF_CONFIG) begin
        next_prdata = {24'h0, converter_configuration};
    end else if (paddr == `ARCC_OFF_PIN_CTRL) begin
        next_prdata[CHANNELS-1:0] = analog_pin_control_lo;
    end else if (paddr == `ARCC_OFF_CMP_CTRL) begin
        next_prdata = {30'h0, compare_greater_equal_select, compare_enable};
    end else begin
        next_err = 1'b1;
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else if (clk_en) begin
        pready <= psel && !penable;
        pslverr <= psel && !penable && next_err;
        if (psel && !penable && !pwrite)
            prdata <= next_prdata;
    end
end
// ----------------------------------------
// outputs to core and pins
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        conv_tick <= 1'b0;
        low_power <= 1'b0;
        long_sample <= 1'b0;
        ten_bit_mode <= 1'b0;
        result_valid <= 1'b0;
        pin_out_disable <= {CHANNELS{1'b0}};
        pin_in_disable <= {CHANNELS{1'b0}};
        pin_pullup_disable <= {CHANNELS{1'b0}};
    end else if (clk_en) begin
        conv_tick <= tick;
        low_power <= converter_configuration[`ARCC_CFG_LOW_POWER];
        long_sample <= converter_configuration[`ARCC_CFG_LONG_SAMPLE];
        ten_bit_mode <= ten_bit;
        result_valid <= low_valid;
        pin_out_disable <= analog_pin_control_lo;
        pin_in_disable <= analog_pin_control_lo;
        pin_pullup_disable <= analog_pin_control_lo;
    end
end
endmodule // arcc_top
`default_nettype wire

// ---- bench/arcc_monitor.sv ----
// assertion checker for the converter register block
`default_nettype none
module arcc_monitor #(
    parameter CHANNELS = 8
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // core and pins
    input wire logic conv_done,
    input wire logic low_power,
    input wire logic long_sample,
    input wire logic ten_bit_mode,
    input wire logic result_valid,
    input wire logic [CHANNELS-1:0] pin_out_disable,
    input wire logic [CHANNELS-1:0] pin_in_disable,
    input wire logic [CHANNELS-1:0] pin_pullup_disable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    logic cfg_wr;
    logic done;
    logic [7:0] wd;
    assign done = psel && penable && pready;
    assign cfg_wr = done && pwrite && paddr == 12'h010;
    assign wd = pwdata[7:0];
    chk_ready_first: assert property (psel && !penable |=> pready)
        else $error("pready missing in first access cycle");
    chk_unmapped_err: assert property (done && paddr > 12'h018 |-> pslverr)
        else $error("unmapped access without error");
    chk_result_noerr: assert property (done && paddr <= 12'h004 |-> !pslverr)
        else $error("result access flagged as error");
    chk_pin_copies: assert property (pin_in_disable == pin_out_disable
        && pin_pullup_disable == pin_out_disable)
        else $error("pin disables disagree");
    chk_mode_follow: assert property (cfg_wr |=> ##1 ten_bit_mode == ($past(wd[3:2], 2) == 2'h2))
        else $error("mode output wrong after config write");
    chk_lp_follow: assert property (cfg_wr |=> ##1 low_power == $past(wd[7], 2))
        else $error("low power output wrong");
    chk_ls_follow: assert property (cfg_wr |=> ##1 long_sample == $past(wd[4], 2))
        else $error("long sample output wrong");
    chk_valid_cause: assert property ($rose(result_valid) |-> $past(conv_done, 2))
        else $error("result valid without conversion");
endmodule // arcc_monitor

bind arcc_top arcc_monitor #(.CHANNELS(CHANNELS)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .low_power(low_power),
    .long_sample(long_sample), .ten_bit_mode(ten_bit_mode), .result_valid(result_valid),
    .pin_out_disable(pin_out_disable), .pin_in_disable(pin_in_disable),
    .pin_pullup_disable(pin_pullup_disable));
`default_nettype wire

// ---- bench/arcc_top_tb.sv ----
// self-checking bench for the converter register block
`default_nettype none
module arcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic conv_done = 0, alt_tick = 0, async_tick = 0, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [9:0] conv_result = 0;
    logic [31:0] prdata;
    logic pready, pslverr, conv_tick, low_power, long_sample, ten_bit_mode, result_valid;
    logic [7:0] pin_out_disable, pin_in_disable, pin_pullup_disable;
    int mismatches = 0, check_count = 0, cyc = 0, n;
    arcc_top uut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_done(conv_done), .conv_result(conv_result),
        .alt_tick(alt_tick), .async_tick(async_tick), .conv_tick(conv_tick),
        .low_power(low_power), .long_sample(long_sample), .ten_bit_mode(ten_bit_mode),
        .result_valid(result_valid), .pin_out_disable(pin_out_disable),
        .pin_in_disable(pin_in_disable), .pin_pullup_disable(pin_pullup_disable)
    );
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        alt_tick <= cyc % 4 == 0;
        async_tick <= cyc % 8 == 0;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20) begin
            mismatches++;
            results;
        end
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1, d);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        xfer(a, 0, 0);
        chk(nm, e, rd);
    endtask
    task conv(input logic [9:0] v);
        conv_done <= 1;
        conv_result <= v;
        @(posedge pclk);
        conv_done <= 0;
        @(posedge pclk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        for (int i = 0; i < 7; i++) rdc(12'(i * 4), 0, "reset value");
        rdc(12'h01c, 0, "unmapped data");
        chk("unmapped err", 1, er);
        wr(12'h004, 32'h5a);
        rdc(12'h004, 0, "result read only");
        wr(12'h008, 32'h3);
        wr(12'h00c, 32'hc3);
        wr(12'h014, 32'ha5);
        rdc(12'h008, 32'h3, "cmp high");
        rdc(12'h00c, 32'hc3, "cmp low");
        rdc(12'h014, 32'ha5, "pin ctrl");
        chk("pin disable", 32'ha5, pin_out_disable);
        chk("pin in disable", 32'ha5, pin_in_disable);
        chk("pin pullup disable", 32'ha5, pin_pullup_disable);
    endtask
    task automatic t_cfg;
        logic [7:0] c [6] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h0c, 8'h00};
        foreach (c[i]) begin
            wr(12'h010, c[i]);
            @(posedge pclk);
            chk("low power", c[i][7], low_power);
            chk("long sample", c[i][4], long_sample);
            chk("mode", c[i][3:2] == 2'h2, ten_bit_mode);
            rdc(12'h010, c[i], "config");
        end
    endtask
    task automatic t_tick;
        logic [7:0] cf [8] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h02, 8'h03, 8'h61};
        int ex [8] = '{64, 32, 16, 8, 32, 16, 8, 4};
        int cnt;
        foreach (cf[i]) begin
            wr(12'h010, cf[i]);
            repeat (4) @(posedge pclk);
            cnt = 0;
            repeat (64) begin
                @(posedge pclk);
                cnt += conv_tick;
            end
            chk("tick count ok", 1, cnt >= ex[i] - 1 && cnt <= ex[i] + 1);
        end
    endtask
    task t_conv;
        wr(12'h010, 0);
        conv(10'h3a5);
        @(posedge pclk);
        chk("valid", 1, result_valid);
        rdc(12'h000, 0, "high 8bit");
        rdc(12'h004, 8'ha5, "low 8bit");
        wr(12'h010, 8'h08);
        @(posedge pclk);
        chk("valid after mode", 0, result_valid);
        conv(10'h2c3);
        rdc(12'h000, 2, "high 10bit");
        rdc(12'h004, 8'hc3, "low 10bit");
        wr(12'h008, 1);
        wr(12'h00c, 0);
        wr(12'h018, 1);
        conv(10'h0f0);
        conv(10'h1ff);
        rdc(12'h000, 0, "lt high");
        rdc(12'h004, 8'hf0, "lt low");
        wr(12'h018, 3);
        conv(10'h0f1);
        conv(10'h180);
        rdc(12'h000, 1, "ge high");
        rdc(12'h004, 8'h80, "ge low");
        wr(12'h010, 0);
        wr(12'h018, 1);
        wr(12'h00c, 8'h80);
        conv(10'h340);
        conv(10'h090);
        rdc(12'h004, 8'h40, "8bit compare");
    endtask
    task t_lock;
        wr(12'h018, 0);
        wr(12'h010, 8'h08);
        conv(10'h155);
        rdc(12'h000, 1, "lock high");
        conv(10'h2aa);
        rdc(12'h004, 8'h55, "locked low");
        conv(10'h0ff);
        rdc(12'h000, 0, "unlocked high");
        rdc(12'h004, 8'hff, "unlocked low");
        wr(12'h010, 0);
        conv(10'h011);
        rdc(12'h000, 0, "8bit high");
        conv(10'h022);
        rdc(12'h004, 8'h22, "no interlock");
    endtask
    task t_freeze;
        conv(10'h0aa);
        clk_en <= 0;
        conv(10'h055);
        @(posedge pclk);
        clk_en <= 1;
        rdc(12'h004, 8'haa, "frozen result");
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rdc(12'h004, 0, "result after reset");
        rdc(12'h014, 0, "pin ctrl after reset");
        chk("pin after reset", 0, pin_out_disable);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_regs;
        t_cfg;
        t_tick;
        t_conv;
        t_lock;
        t_freeze;
        results;
    end
endmodule // arcc_top_tb
`default_nettype wire
